/* rtl/iro_exec.sv */
`timescale 1ns/1ps
`include "iro_params.svh"
module iro_exec #(
   parameter int PC_W = 13
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [13:0] instr,
   input wire logic instr_valid,
   input wire logic [PC_W-1:0] stack_top_entry,
   input wire logic [7:0] w_reg,
   output logic [PC_W-1:0] pc_q,
   output logic [7:0] irq_control_reg_q,
   output logic [7:0] option_q,
   output logic stack_pop,
   output logic busy,
   output logic [1:0] q_phase
);
   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   // idle pattern: bits 6 and 5 are ignored
   function automatic logic is_idle(input logic [13:0] op);
      return (op & `IRO_IDLE_MASK) == `IRO_IDLE_CODE;
   endfunction

   // exact word matches shared by next-state logic and checks
   function automatic logic is_irq_ret(input logic [13:0] op);
      return op == `IRO_IRQ_RET_CODE;
   endfunction

   function automatic logic is_opt_load(input logic [13:0] op);
      return op == `IRO_OPT_LOAD_CODE;
   endfunction

   iro_pkg::iro_state_e st_q, st_d;
   iro_pkg::iro_phase_t ph_q, ph_d;
   logic [PC_W-1:0] pc_d;
   logic [7:0] ictl_d, opt_d;
   logic [13:0] op_q, op_d;
   logic pop_d, pop_q;

   // next state: one instruction cycle per four quarter phases
   always_comb begin
      st_d = st_q;
      ph_d = ph_q + 2'h1;
      op_d = op_q;
      pc_d = pc_q;
      ictl_d = irq_control_reg_q;
      opt_d = option_q;
      pop_d = 1'b0;
      case (st_q)
         iro_pkg::IRO_IDLE_ST: begin
            // q1 decode of a new word
            if (ph_q == 2'h0 && instr_valid) begin
               op_d = instr;
               if (!is_idle(instr)) begin
                  st_d = iro_pkg::IRO_EXEC_ST;
               end
            end
         end
         iro_pkg::IRO_EXEC_ST: begin
            if (is_irq_ret(op_q)) begin
               if (ph_q == 2'h2) begin
                  ictl_d[`IRO_GLOBAL_IRQ_ENABLE_BIT] = 1'b1;
               end
               if (ph_q == 2'h3) begin
                  pc_d = stack_top_entry;
                  pop_d = 1'b1;
                  st_d = iro_pkg::IRO_FILL_ST;
               end
            end else if (is_opt_load(op_q)) begin
               if (ph_q == 2'h3) begin
                  opt_d = w_reg;
                  st_d = iro_pkg::IRO_IDLE_ST;
               end
            end else if (ph_q == 2'h3) begin
               st_d = iro_pkg::IRO_IDLE_ST;
            end
         end
         iro_pkg::IRO_FILL_ST: begin
            // refill cycle does nothing
            if (ph_q == 2'h3) begin
               st_d = iro_pkg::IRO_IDLE_ST;
            end
         end
         default: st_d = iro_pkg::IRO_IDLE_ST;
      endcase
   end

   // registers
   always_ff @(posedge mclk) begin
      if (srst) begin
         st_q <= iro_pkg::IRO_IDLE_ST;
         ph_q <= 2'h0;
         op_q <= 14'h0000;
         pc_q <= PC_W'(`IRO_PC_RST);
         irq_control_reg_q <= `IRO_IRQ_CTL_RST;
         option_q <= `IRO_OPT_RST;
         pop_q <= 1'b0;
      end else begin
         st_q <= st_d;
         ph_q <= ph_d;
         op_q <= op_d;
         pc_q <= pc_d;
         irq_control_reg_q <= ictl_d;
         option_q <= opt_d;
         pop_q <= pop_d;
      end
   end

   assign stack_pop = pop_q;
   assign busy = (st_q != iro_pkg::IRO_IDLE_ST);
   assign q_phase = ph_q;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   // execution points that the checks refer to
   logic word_take;
   logic ret_set_pt;
   logic ret_pop_pt;
   logic opt_load_pt;
   assign word_take = st_q == iro_pkg::IRO_IDLE_ST && ph_q == 2'h0
      && instr_valid;
   assign ret_set_pt = st_q == iro_pkg::IRO_EXEC_ST && is_irq_ret(op_q)
      && ph_q == 2'h2;
   assign ret_pop_pt = st_q == iro_pkg::IRO_EXEC_ST && is_irq_ret(op_q)
      && ph_q == 2'h3;
   assign opt_load_pt = st_q == iro_pkg::IRO_EXEC_ST
      && is_opt_load(op_q) && ph_q == 2'h3;

   // idle word: nothing moves and the core stays free
   idle_no_change_a: assert property (@(posedge mclk)
      disable iff (srst)
      (word_take && is_idle(instr)) |=> ($stable(pc_q)
      && $stable(option_q) && $stable(irq_control_reg_q)
      && !stack_pop && st_q == iro_pkg::IRO_IDLE_ST))
      else $error("idle word changed state");
   idle_one_cycle_a: assert property (@(posedge mclk)
      disable iff (srst)
      (word_take && is_idle(instr)) |=> (!busy)[*4])
      else $error("idle word took too long");
   // words are only taken in the first quarter phase
   late_word_a: assert property (@(posedge mclk)
      disable iff (srst)
      (!busy && ph_q != 2'h0) |=> !busy)
      else $error("word taken outside the first phase");
   // the quarter phase counter never skips or stalls
   phase_step_a: assert property (@(posedge mclk)
      disable iff (srst)
      !$past(srst) |-> q_phase == 2'($past(q_phase) + 2'h1))
      else $error("quarter phase did not advance");

   // irq return: enable in q3, pop and pc load in q4, then a refill
   ret_enable_time_a: assert property (@(posedge mclk)
      disable iff (srst)
      ret_set_pt |=> irq_control_reg_q[`IRO_GLOBAL_IRQ_ENABLE_BIT])
      else $error("interrupt enable not set in the third phase");
   ret_irq_enable_a: assert property (@(posedge mclk)
      disable iff (srst)
      $rose(stack_pop) |-> irq_control_reg_q[`IRO_GLOBAL_IRQ_ENABLE_BIT])
      else $error("interrupt enable not set");
   // only the enable bit is ever written here
   ictl_low_bits_a: assert property (@(posedge mclk)
      disable iff (srst)
      1'b1 |=> $stable(irq_control_reg_q[6:0]))
      else $error("interrupt control low bits changed");
   ret_pop_time_a: assert property (@(posedge mclk)
      disable iff (srst)
      ret_pop_pt |=> (stack_pop && pc_q == $past(stack_top_entry)))
      else $error("stack not popped in the fourth phase");
   ret_pop_pc_a: assert property (@(posedge mclk)
      disable iff (srst)
      $rose(stack_pop) |-> pc_q == $past(stack_top_entry))
      else $error("pc not loaded from stack top");
   // a pop is a single pulse and the pc moves only with it
   pop_single_a: assert property (@(posedge mclk)
      disable iff (srst)
      stack_pop |=> !stack_pop)
      else $error("stack popped twice");
   pc_hold_a: assert property (@(posedge mclk)
      disable iff (srst)
      !ret_pop_pt |=> $stable(pc_q))
      else $error("pc changed outside an irq return");
   ret_two_cycles_a: assert property (@(posedge mclk)
      disable iff (srst)
      $rose(stack_pop) |-> busy[*4] ##1 !busy)
      else $error("irq return length wrong");
   ret_take_len_a: assert property (@(posedge mclk)
      disable iff (srst)
      (word_take && is_irq_ret(instr)) |=> busy[*7] ##1 !busy)
      else $error("irq return does not span two cycles");

   // option load: one cycle, w lands in q4
   opt_load_a: assert property (@(posedge mclk)
      disable iff (srst)
      opt_load_pt |=> (option_q == $past(w_reg) && !busy))
      else $error("option load wrong");
   opt_stable_a: assert property (@(posedge mclk)
      disable iff (srst)
      !opt_load_pt |=> $stable(option_q))
      else $error("option changed unexpectedly");
   opt_one_cycle_a: assert property (@(posedge mclk)
      disable iff (srst)
      (word_take && is_opt_load(instr)) |=> busy[*3] ##1 !busy)
      else $error("option load does not take one cycle");

   // main scenarios
   ret_cov_c: cover property (@(posedge mclk) disable iff (srst)
      $rose(stack_pop));
   opt_cov_c: cover property (@(posedge mclk) disable iff (srst)
      opt_load_pt);
   idle_cov_c: cover property (@(posedge mclk) disable iff (srst)
      word_take && is_idle(instr));
   other_cov_c: cover property (@(posedge mclk) disable iff (srst)
      word_take && !is_idle(instr) && !is_irq_ret(instr)
      && !is_opt_load(instr));
endmodule

/* rtl/iro_params.svh */
`ifndef IRO_PARAMS_SVH
`define IRO_PARAMS_SVH
// ----------------------------------------
// opcode patterns
// ----------------------------------------
`define IRO_IDLE_MASK 14'h3F9F
`define IRO_IDLE_CODE 14'h0000
`define IRO_IRQ_RET_CODE 14'h0009
`define IRO_OPT_LOAD_CODE 14'h0062
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define IRO_GLOBAL_IRQ_ENABLE_BIT 7
`define IRO_PC_RST 13'h0000
`define IRO_OPT_RST 8'hFF
`define IRO_IRQ_CTL_RST 8'h00
// ----------------------------------------
// timing in instruction cycles and phases
// ----------------------------------------
`define IRO_Q_PER_CYCLE 4
`define IRO_IRQ_RET_CYCLES 2
`endif

/* rtl/iro_pkg.sv */
package iro_pkg;
   typedef enum logic [2:0] {
      IRO_IDLE_ST = 3'h1,
      IRO_EXEC_ST = 3'h2,
      IRO_FILL_ST = 3'h4
   } iro_state_e;
   typedef logic [1:0] iro_phase_t;
endpackage

/* sim/idle_irq_return_option_exec_test.sv */
`timescale 1ns/1ps
module idle_irq_return_option_exec_test;
   logic mclk, srst, instr_valid, stack_pop, busy;
   logic [13:0] instr;
   logic [12:0] top, pc_q;
   logic [7:0] w_reg, ictl, opt;
   logic [1:0] q_phase;
   int fails = 0;
   int tests_run = 0;
   int cyc = 0;
   iro_exec u_iro_exec (.mclk(mclk), .srst(srst), .instr(instr),
      .instr_valid(instr_valid), .stack_top_entry(top), .w_reg(w_reg),
      .pc_q(pc_q), .irq_control_reg_q(ictl), .option_q(opt),
      .stack_pop(stack_pop), .busy(busy), .q_phase(q_phase));
   // -------------------------------
   // clock, hang guard, helpers
   // -------------------------------
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         fails++;
         print_verdict();
      end
   end
   task automatic chk(input string n, input logic [15:0] e, logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   // offer a word so it is taken at the first q1 edge; returns at it
   task automatic go(input logic [13:0] word);
      @(negedge mclk);
      while (q_phase !== 2'h3) @(negedge mclk);
      @(posedge mclk);
      instr <= word;
      instr_valid <= 1'b1;
      @(posedge mclk);
      instr_valid <= 1'b0;
   endtask
   task automatic after(input int k);
      repeat (k) @(posedge mclk);
      @(negedge mclk);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // -------------------------------
   // scenarios
   // -------------------------------
   task automatic test_idle;
      for (int i = 0; i < 4; i++) begin
         go({7'h00, i[1:0], 5'h00});
         after(0);
         chk("idle busy", 16'h0000, busy);
         chk("idle phase", 16'h0001, q_phase);
         after(3);
         chk("idle pc", 16'h0000, pc_q);
         chk("idle ictl", 16'h0000, ictl);
         chk("idle option", 16'h00FF, opt);
      end
      $display("idle test done");
   endtask
   // option load checks, then a plain word that must leave pc and stack alone
   task automatic test_opt;
      go(14'h0062);
      after(2);
      chk("option early", 16'h00FF, opt);
      after(1);
      chk("option", 16'h004F, opt);
      chk("opt busy", 16'h0000, busy);
      @(posedge mclk);
      w_reg <= 8'hA5;
      go(14'h0062);
      after(4);
      chk("option again", 16'h00A5, opt);
      chk("opt pc", 16'h0000, pc_q);
      go(14'h0008);
      after(0);
      chk("other busy", 16'h0001, busy);
      after(3);
      chk("other done", 16'h0000, busy);
      chk("other pc", 16'h0000, pc_q);
      chk("other pop", 16'h0000, stack_pop);
      $display("option load test done");
   endtask
   task automatic test_irq;
      @(posedge mclk);
      top <= 13'h1ABC;
      go(14'h0009);
      after(1);
      chk("enable early", 16'h0000, ictl);
      after(1);
      chk("enable set", 16'h0080, ictl);
      after(1);
      chk("pc load", 16'h1ABC, pc_q);
      chk("pop", 16'h0001, stack_pop);
      after(1);
      chk("pop end", 16'h0000, stack_pop);
      after(2);
      chk("ret busy", 16'h0001, busy);
      after(1);
      chk("ret done", 16'h0000, busy);
      chk("ret option", 16'h00A5, opt);
      $display("irq return test done");
   endtask
   initial begin
      srst = 1'b1;
      instr = 14'h0000;
      instr_valid = 1'b0;
      top = 13'h0155;
      w_reg = 8'h4F;
      repeat (6) @(posedge mclk);
      srst <= 1'b0;
      test_idle;
      test_opt;
      test_irq;
      print_verdict;
   end
endmodule
